/* File: core/status_interrupt_and_clock_out.sv */
// interrupt flags, masks, raw status and divided clock output, APB slave
// assumes source levels are synchronous to clk; detector datapaths live elsewhere
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module status_interrupt_and_clock_out #(
	parameter int ADDR_WIDTH = 16,
	parameter int DEBOUNCE_COUNT = status_irq_pkg::DEBOUNCE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] rateLock,
	input wire logic [1:0] controllerEnabled,
	input wire logic [1:0] activityRaw,
	input wire logic fifoMismatch,
	input wire logic thermalWarning,
	input wire logic thermalShutdown,
	input wire logic pinTenLevel,
	input wire logic pinElevenLevel,
	output logic irq,
	output logic [1:0] rateLockLevel,
	output logic [1:0] activityLevel,
	output logic fifoErrorLevel,
	output logic [1:0] activityThresholdType,
	output logic [1:0][9:0] activityThresholdTenthsDb,
	output logic gpioClockOutput,
	output logic gpioClockTick
);
	import status_irq_pkg::*;

	// =========================================================
	// state
	typedef struct packed {
		logic clkOutEnable; // clock output run bit
		logic [2:0] divCode; // divider code
		logic [1:0][15:0] actCfg; // activity detect config per path
		logic [15:0] flagsOne; // pin edge flags
		logic [15:0] flagsTwo; // status edge flags
		logic [15:0] maskOne; // per source masks, first group
		logic [15:0] maskTwo; // per source masks, second group
		logic globalMask; // request suppress
		logic [15:0] debounceCfg; // filter enables
		logic [8:0] lvl; // last sampled source levels
		logic [31:0] rdata; // read data, captured in setup phase
		logic [3:0] divCnt; // divider phase
		logic clkOut; // divided clock level
		logic tick; // one pulse per divided period
		logic irq; // request output
		logic [1:0][9:0] thr; // decoded thresholds
	} state_type;

	state_type st_q;
	state_type st_d;

	logic [8:0] lvlNow; // present source levels
	logic [8:0] events; // qualifying edges this cycle
	logic [15:0] setOne; // flag sets, first group
	logic [15:0] setTwo; // flag sets, second group
	logic [15:0] clrOne; // write-one clears, first group
	logic [15:0] clrTwo; // write-one clears, second group
	logic [15:0] byteMask; // lanes being written
	logic [15:0] wdata; // low half of write data
	logic [11:0] regIdx; // word index of the access
	logic mapped; // address hits a register
	logic wrEn; // write takes effect this edge
	logic [4:0] divisor; // present divide ratio
	logic [3:0] nextCnt; // divider phase after this edge

	debounce_if #(.CHANNELS(DB_CHANNELS)) dbLink();

	// =========================================================
	// helpers
	function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] a);
		if (a[1:0] != 2'h0 || (a >> 14) != '0) begin
			return 1'b0;
		end
		case (a[13:2])
			IDX_POWER_ENABLES_2, IDX_CLOCK_OUTPUT_DIVIDER_CFG, IDX_PATH_ONE_ACTIVITY_CFG,
			IDX_PATH_TWO_ACTIVITY_CFG, IDX_INTERRUPT_FLAGS_ONE, IDX_INTERRUPT_FLAGS_TWO,
			IDX_RAW_STATUS_TWO, IDX_FLAG_MASK_ONE, IDX_FLAG_MASK_TWO, IDX_REQUEST_CONTROL,
			IDX_DEBOUNCE_CFG: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// byte-lane merge of a write into a stored value
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] bm, input logic [15:0] used);
		return ((old & ~bm) | (wd & bm)) & used;
	endfunction

	// any unmasked flag, gated by the global mask
	function automatic logic pending(input state_type s);
		return !s.globalMask && |((s.flagsOne & ~s.maskOne) | (s.flagsTwo & ~s.maskTwo));
	endfunction

	// =========================================================
	// bus decode
	assign regIdx = paddr[13:2];
	assign mapped = isMapped(paddr);
	assign wrEn = psel && penable && pwrite && mapped;
	assign byteMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wdata = pwdata[15:0];
	assign clrOne = (wrEn && regIdx == IDX_INTERRUPT_FLAGS_ONE) ? (wdata & byteMask) : 16'h0000;
	assign clrTwo = (wrEn && regIdx == IDX_INTERRUPT_FLAGS_TWO) ? (wdata & byteMask) : 16'h0000;

	// =========================================================
	// de-bounce of rate lock and thermal inputs
	assign dbLink.raw[DB_RATE_ONE] = rateLock[0];
	assign dbLink.raw[DB_RATE_TWO] = rateLock[1];
	assign dbLink.raw[DB_WARN] = thermalWarning;
	assign dbLink.raw[DB_SHUT] = thermalShutdown;
	assign dbLink.enable[DB_RATE_ONE] = st_q.debounceCfg[DB_RATE_ONE_BIT];
	assign dbLink.enable[DB_RATE_TWO] = st_q.debounceCfg[DB_RATE_TWO_BIT];
	assign dbLink.enable[DB_WARN] = st_q.debounceCfg[DB_WARN_BIT];
	assign dbLink.enable[DB_SHUT] = st_q.debounceCfg[DB_SHUT_BIT];

	debounce_filter #(.CHANNELS(DB_CHANNELS), .COUNT(DEBOUNCE_COUNT)) filterUnit (
		.clk(clk),
		.rst(rst),
		.link(dbLink)
	);

	// =========================================================
	// source levels and edge qualification
	always_comb begin
		lvlNow = 9'h000;
		lvlNow[LV_RATE_ONE] = dbLink.clean[DB_RATE_ONE];
		lvlNow[LV_RATE_TWO] = dbLink.clean[DB_RATE_TWO];
		for (int i = 0; i < 2; i++) begin
			// detection counts only while its controller runs and it is armed
			lvlNow[LV_ACT_ONE + i] = activityRaw[i] && controllerEnabled[i]
				&& st_q.actCfg[i][DETECT_ENABLE_BIT];
		end
		lvlNow[LV_FIFO] = fifoMismatch;
		lvlNow[LV_WARN] = dbLink.clean[DB_WARN];
		lvlNow[LV_SHUT] = dbLink.clean[DB_SHUT];
		lvlNow[LV_PIN_TEN] = pinTenLevel;
		lvlNow[LV_PIN_ELEVEN] = pinElevenLevel;
	end

	// a change counts on dual-edge sources, a rise on the others
	assign events = (lvlNow ^ st_q.lvl) & (DUAL_EDGE_SOURCES | lvlNow);
	assign setTwo = toFlagsTwo(events);

	always_comb begin
		setOne = 16'h0000;
		setOne[FLAG_PIN_ELEVEN] = events[LV_PIN_ELEVEN];
		setOne[FLAG_PIN_TEN] = events[LV_PIN_TEN];
	end

	// =========================================================
	// divider phase
	assign divisor = divisorOf(st_q.divCode);
	assign nextCnt = ({1'b0, st_q.divCnt} >= divisor - 5'h01) ? 4'h0 : st_q.divCnt + 4'h1;

	// =========================================================
	// next state
	always_comb begin
		st_d = st_q;
		st_d.lvl = lvlNow;
		// set wins over clear, so no edge is lost
		st_d.flagsOne = ((st_q.flagsOne & ~clrOne) | setOne) & FLAGS_ONE_USED;
		st_d.flagsTwo = ((st_q.flagsTwo & ~clrTwo) | setTwo) & FLAGS_TWO_USED;
		if (wrEn) begin
			case (regIdx)
				IDX_POWER_ENABLES_2: begin
					st_d.clkOutEnable = pstrb[1] ? wdata[CLKOUT_ENABLE_BIT] : st_q.clkOutEnable;
				end
				IDX_CLOCK_OUTPUT_DIVIDER_CFG: begin
					st_d.divCode = pstrb[0] ? wdata[DIV_CODE_LSB +: DIV_CODE_W] : st_q.divCode;
				end
				IDX_PATH_ONE_ACTIVITY_CFG: begin
					st_d.actCfg[0] = merge(st_q.actCfg[0], wdata, byteMask, ACTIVITY_CFG_USED);
				end
				IDX_PATH_TWO_ACTIVITY_CFG: begin
					st_d.actCfg[1] = merge(st_q.actCfg[1], wdata, byteMask, ACTIVITY_CFG_USED);
				end
				IDX_FLAG_MASK_ONE: begin
					st_d.maskOne = merge(st_q.maskOne, wdata, byteMask, FLAGS_ONE_USED);
				end
				IDX_FLAG_MASK_TWO: begin
					st_d.maskTwo = merge(st_q.maskTwo, wdata, byteMask, FLAGS_TWO_USED);
				end
				IDX_REQUEST_CONTROL: begin
					st_d.globalMask = pstrb[0] ? wdata[GLOBAL_MASK_BIT] : st_q.globalMask;
				end
				IDX_DEBOUNCE_CFG: begin
					st_d.debounceCfg = merge(st_q.debounceCfg, wdata, byteMask, DEBOUNCE_USED);
				end
				default: begin
					// flags are handled above, raw status is read only
				end
			endcase
		end
		// read data is latched in setup so it is steady through access
		if (psel && !penable && !pwrite) begin
			st_d.rdata = 32'h0000_0000;
			// misaligned or out-of-range addresses fall to the zero default
			case (mapped ? regIdx : 12'h000)
				IDX_POWER_ENABLES_2: st_d.rdata[CLKOUT_ENABLE_BIT] = st_q.clkOutEnable;
				IDX_CLOCK_OUTPUT_DIVIDER_CFG: st_d.rdata[DIV_CODE_LSB +: DIV_CODE_W] = st_q.divCode;
				IDX_PATH_ONE_ACTIVITY_CFG: st_d.rdata[15:0] = st_q.actCfg[0];
				IDX_PATH_TWO_ACTIVITY_CFG: st_d.rdata[15:0] = st_q.actCfg[1];
				IDX_INTERRUPT_FLAGS_ONE: st_d.rdata[15:0] = st_q.flagsOne;
				IDX_INTERRUPT_FLAGS_TWO: st_d.rdata[15:0] = st_q.flagsTwo;
				IDX_RAW_STATUS_TWO: st_d.rdata[15:0] = toFlagsTwo(st_q.lvl);
				IDX_FLAG_MASK_ONE: st_d.rdata[15:0] = st_q.maskOne;
				IDX_FLAG_MASK_TWO: st_d.rdata[15:0] = st_q.maskTwo;
				IDX_REQUEST_CONTROL: st_d.rdata[GLOBAL_MASK_BIT] = st_q.globalMask;
				IDX_DEBOUNCE_CFG: st_d.rdata[15:0] = st_q.debounceCfg;
				default: st_d.rdata = 32'h0000_0000; // unmapped reads zero
			endcase
		end
		// request follows the flags of this same edge
		st_d.irq = pending(st_d);
		for (int i = 0; i < 2; i++) begin
			st_d.thr[i] = thresholdTenths(st_d.actCfg[i]);
		end
		// divided clock; ratio one holds the level high, only tick runs
		if (!st_q.clkOutEnable) begin
			st_d.divCnt = 4'h0;
			st_d.clkOut = 1'b0;
			st_d.tick = 1'b0;
		end else begin
			st_d.divCnt = nextCnt;
			st_d.clkOut = {1'b0, nextCnt} < ((divisor + 5'h01) >> 1);
			st_d.tick = nextCnt == 4'h0;
		end
	end

	// state register with documented reset values
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
			st_q.actCfg <= {ACTIVITY_CFG_RESET, ACTIVITY_CFG_RESET};
			st_q.maskOne <= FLAGS_ONE_USED;
			st_q.maskTwo <= FLAGS_TWO_USED;
			st_q.debounceCfg <= DEBOUNCE_RESET;
			st_q.thr <= {10'(LEVEL_BASE_TENTHS), 10'(LEVEL_BASE_TENTHS)};
		end else begin
			st_q <= st_d;
		end
	end

	// =========================================================
	// outputs
	assign prdata = st_q.rdata;
	assign pready = 1'b1; // no wait states
	assign pslverr = psel && penable && !mapped;
	assign irq = st_q.irq;
	assign rateLockLevel = {st_q.lvl[LV_RATE_TWO], st_q.lvl[LV_RATE_ONE]};
	assign activityLevel = {st_q.lvl[LV_ACT_TWO], st_q.lvl[LV_ACT_ONE]};
	assign fifoErrorLevel = st_q.lvl[LV_FIFO];
	assign activityThresholdType = {st_q.actCfg[1][THR_TYPE_BIT], st_q.actCfg[0][THR_TYPE_BIT]};
	assign activityThresholdTenthsDb = st_q.thr;
	assign gpioClockOutput = st_q.clkOut;
	assign gpioClockTick = st_q.tick;

	// =========================================================
	// checks
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		(($past(st_q.flagsTwo) & ~$past(clrTwo) & ~st_q.flagsTwo) == 16'h0000))
		else $error("flag dropped without a clear");
	a_set_wins: assert property (@(posedge clk) disable iff (rst)
		(($past(setTwo) & ~st_q.flagsTwo) == 16'h0000))
		else $error("edge lost against a clear");
	a_pin_edges: assert property (@(posedge clk) disable iff (rst)
		$changed(pinTenLevel) |=> st_q.flagsOne[FLAG_PIN_TEN])
		else $error("pin ten edge did not set its flag");
	a_rate_edges: assert property (@(posedge clk) disable iff (rst)
		$changed(dbLink.clean[DB_RATE_ONE]) |=> st_q.flagsTwo[FLAG_RATE_ONE])
		else $error("rate lock edge did not set its flag");
	a_fifo_rise: assert property (@(posedge clk) disable iff (rst)
		$rose(fifoMismatch) |=> st_q.flagsTwo[FLAG_FIFO])
		else $error("fifo error rise did not set its flag");
	a_act_no_fall: assert property (@(posedge clk) disable iff (rst)
		(st_q.lvl[LV_ACT_ONE] && !lvlNow[LV_ACT_ONE] && !st_q.flagsTwo[FLAG_ACT_ONE])
		|=> !st_q.flagsTwo[FLAG_ACT_ONE])
		else $error("activity fall set its flag");
	a_act_gated: assert property (@(posedge clk) disable iff (rst)
		!(controllerEnabled[0] && st_q.actCfg[0][DETECT_ENABLE_BIT]) |=> !activityLevel[0])
		else $error("activity seen while detection off");
	a_request_or: assert property (@(posedge clk) disable iff (rst)
		irq == (!st_q.globalMask && |((st_q.flagsOne & ~st_q.maskOne) | (st_q.flagsTwo & ~st_q.maskTwo))))
		else $error("request differs from unmasked flags");
	a_global_mask: assert property (@(posedge clk) disable iff (rst)
		st_q.globalMask |-> !irq)
		else $error("request while globally masked");
	a_mask_blocks: assert property (@(posedge clk) disable iff (rst)
		(st_q.maskOne == FLAGS_ONE_USED && st_q.maskTwo == FLAGS_TWO_USED) |-> !irq)
		else $error("masked flag raised the request");
	a_level_floor: assert property (@(posedge clk) disable iff (rst)
		(st_q.actCfg[0][THR_TYPE_BIT] && st_q.actCfg[0][LEVEL_THR_LSB +: LEVEL_THR_W] == 5'h1f)
		|-> activityThresholdTenthsDb[0] == 10'h2fd)
		else $error("level threshold code 31 is not 76.5dB");
	a_crest_top: assert property (@(posedge clk) disable iff (rst)
		(!st_q.actCfg[1][THR_TYPE_BIT] && st_q.actCfg[1][CREST_THR_LSB +: CREST_THR_W] == 2'h3)
		|-> activityThresholdTenthsDb[1] == 10'h12c)
		else $error("crest threshold code 3 is not 30dB");
	a_clock_gated: assert property (@(posedge clk) disable iff (rst)
		!st_q.clkOutEnable |=> (!gpioClockOutput && !gpioClockTick))
		else $error("clock output runs while disabled");
	a_div_four: assert property (@(posedge clk) disable iff (rst)
		(gpioClockTick && st_q.clkOutEnable && st_q.divCode == 3'h3)
		##1 (st_q.clkOutEnable && st_q.divCode == 3'h3)[*3] |=> gpioClockTick)
		else $error("divide by four period wrong");

	c_request_raised: cover property (@(posedge clk) disable iff (rst) $rose(irq));
	c_clear_collides: cover property (@(posedge clk) disable iff (rst) |(setTwo & clrTwo));
	c_rate_lock_lost: cover property (@(posedge clk) disable iff (rst) $fell(rateLockLevel[1]));
	c_div_sixteen: cover property (@(posedge clk) disable iff (rst) gpioClockTick && st_q.divCode == 3'h7);

endmodule
`default_nettype wire

/* File: core/status_irq_pkg.sv */
// constants, field layouts and helpers for the status interrupt block
// assumes a 50 MHz system clock and one aligned 32-bit word per register index
package status_irq_pkg;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [11:0] IDX_POWER_ENABLES_2 = 12'h002;
	localparam logic [11:0] IDX_CLOCK_OUTPUT_DIVIDER_CFG = 12'h209;
	localparam logic [11:0] IDX_PATH_ONE_ACTIVITY_CFG = 12'h440;
	localparam logic [11:0] IDX_PATH_TWO_ACTIVITY_CFG = 12'h540;
	localparam logic [11:0] IDX_INTERRUPT_FLAGS_ONE = 12'h730;
	localparam logic [11:0] IDX_INTERRUPT_FLAGS_TWO = 12'h731;
	localparam logic [11:0] IDX_RAW_STATUS_TWO = 12'h732;
	localparam logic [11:0] IDX_FLAG_MASK_ONE = 12'h738;
	localparam logic [11:0] IDX_FLAG_MASK_TWO = 12'h739;
	localparam logic [11:0] IDX_REQUEST_CONTROL = 12'h740;
	localparam logic [11:0] IDX_DEBOUNCE_CFG = 12'h748;

	// ==========================================================
	// field positions
	localparam int CLKOUT_ENABLE_BIT = 11;
	localparam int DIV_CODE_LSB = 0;
	localparam int DIV_CODE_W = 3;
	localparam int LEVEL_THR_LSB = 11;
	localparam int LEVEL_THR_W = 5;
	localparam int CREST_THR_LSB = 9;
	localparam int CREST_THR_W = 2;
	localparam int THR_TYPE_BIT = 7;
	localparam int DETECT_ENABLE_BIT = 6;
	localparam int FLAG_PIN_ELEVEN = 10;
	localparam int FLAG_PIN_TEN = 9;
	localparam int FLAG_WARN = 15;
	localparam int FLAG_FIFO = 12;
	localparam int FLAG_ACT_TWO = 11;
	localparam int FLAG_ACT_ONE = 9;
	localparam int FLAG_RATE_TWO = 8;
	localparam int FLAG_RATE_ONE = 7;
	localparam int FLAG_SHUT = 0;
	localparam int GLOBAL_MASK_BIT = 0;
	localparam int DB_SHUT_BIT = 0;
	localparam int DB_RATE_ONE_BIT = 1;
	localparam int DB_RATE_TWO_BIT = 2;
	localparam int DB_WARN_BIT = 5;

	// ==========================================================
	// implemented bits and reset values
	localparam logic [15:0] FLAGS_ONE_USED = 16'h0600;
	localparam logic [15:0] FLAGS_TWO_USED = 16'h9b81;
	localparam logic [15:0] ACTIVITY_CFG_USED = 16'hfec0;
	localparam logic [15:0] ACTIVITY_CFG_RESET = 16'h0080;
	localparam logic [15:0] DEBOUNCE_USED = 16'h0027;
	localparam logic [15:0] DEBOUNCE_RESET = 16'h0021;

	// ==========================================================
	// source levels, in one vector
	localparam int LV_RATE_ONE = 0;
	localparam int LV_RATE_TWO = 1;
	localparam int LV_ACT_ONE = 2;
	localparam int LV_ACT_TWO = 3;
	localparam int LV_FIFO = 4;
	localparam int LV_WARN = 5;
	localparam int LV_SHUT = 6;
	localparam int LV_PIN_TEN = 7;
	localparam int LV_PIN_ELEVEN = 8;
	localparam int LEVEL_COUNT = 9;
	localparam logic [8:0] DUAL_EDGE_SOURCES = 9'h1e3;
	localparam int DB_RATE_ONE = 0;
	localparam int DB_RATE_TWO = 1;
	localparam int DB_WARN = 2;
	localparam int DB_SHUT = 3;
	localparam int DB_CHANNELS = 4;

	// ==========================================================
	// timing and thresholds
	localparam int SYS_CLOCK_MHZ = 50;
	localparam int DEBOUNCE_TIME_NS = 20000;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS * SYS_CLOCK_MHZ + 999) / 1000;
	localparam int LEVEL_BASE_TENTHS = 300;
	localparam int LEVEL_STEP_TENTHS = 15;
	localparam int CREST_BASE_TENTHS = 120;
	localparam int CREST_STEP_TENTHS = 60;

	// divide ratio for each divider code
	function automatic logic [4:0] divisorOf(input logic [2:0] code);
		case (code)
			3'h0: return 5'h01;
			3'h1: return 5'h02;
			3'h2: return 5'h03;
			3'h3: return 5'h04;
			3'h4: return 5'h06;
			3'h5: return 5'h08;
			3'h6: return 5'h0c;
			default: return 5'h10;
		endcase
	endfunction

	// threshold magnitude in tenths of a dB (level ones are negative)
	function automatic logic [9:0] thresholdTenths(input logic [15:0] cfg);
		if (cfg[THR_TYPE_BIT]) begin
			return 10'(LEVEL_BASE_TENTHS + LEVEL_STEP_TENTHS * int'(cfg[LEVEL_THR_LSB +: LEVEL_THR_W]));
		end
		return 10'(CREST_BASE_TENTHS + CREST_STEP_TENTHS * int'(cfg[CREST_THR_LSB +: CREST_THR_W]));
	endfunction

	// place source bits at their second flag register positions
	function automatic logic [15:0] toFlagsTwo(input logic [8:0] lv);
		logic [15:0] f;
		f = 16'h0000;
		f[FLAG_WARN] = lv[LV_WARN];
		f[FLAG_FIFO] = lv[LV_FIFO];
		f[FLAG_ACT_TWO] = lv[LV_ACT_TWO];
		f[FLAG_ACT_ONE] = lv[LV_ACT_ONE];
		f[FLAG_RATE_TWO] = lv[LV_RATE_TWO];
		f[FLAG_RATE_ONE] = lv[LV_RATE_ONE];
		f[FLAG_SHUT] = lv[LV_SHUT];
		return f;
	endfunction

endpackage

/* File: core/debounce_if.sv */
// carrier between the interrupt block and its de-bounce filter
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface debounce_if #(parameter int CHANNELS = 4);
	logic [CHANNELS-1:0] raw; // levels before filtering
	logic [CHANNELS-1:0] enable; // per channel filter on
	logic [CHANNELS-1:0] clean; // filtered levels
	modport filter(input raw, input enable, output clean);
	modport user(output raw, output enable, input clean);
endinterface
`default_nettype wire

/* File: core/debounce_filter.sv */
// per channel de-bounce filter for interrupt inputs
// assumes raw levels are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module debounce_filter #(
	parameter int CHANNELS = 4,
	parameter int COUNT = 1000
) (
	input wire logic clk,
	input wire logic rst,
	debounce_if.filter link
);
	localparam int CW = $clog2(COUNT + 1);

	// =========================================================
	// state
	typedef struct packed {
		logic [CHANNELS-1:0][CW-1:0] cnt; // cycles the input has differed
		logic [CHANNELS-1:0] clean; // accepted level
	} state_type;

	state_type st_q;
	state_type st_d;

	// =========================================================
	// filter: on an enabled channel a change is accepted only after COUNT steady cycles
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < CHANNELS; i++) begin
			if (!link.enable[i]) begin
				// bypass still costs one register stage
				st_d.clean[i] = link.raw[i];
				st_d.cnt[i] = '0;
			end else if (link.raw[i] == st_q.clean[i]) begin
				st_d.cnt[i] = '0; // glitch gone, start over
			end else if (st_q.cnt[i] == CW'(COUNT - 1)) begin
				st_d.clean[i] = link.raw[i];
				st_d.cnt[i] = '0;
			end else begin
				st_d.cnt[i] = st_q.cnt[i] + CW'(1);
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign link.clean = st_q.clean;

endmodule
`default_nettype wire

/* File: tb/irq_host_model.sv */
// host side model: notes each new interrupt request
// assumes irq is a synchronous level from the device
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
	input wire logic clk,
	input wire logic irq,
	output int rises
);
	logic seen = 1'b0; // last sampled request level
	int wakeups = 0; // rising requests seen so far
	// host wakes once per rising request and counts the wakeup
	always @(posedge clk) begin
		if (irq && !seen) wakeups <= wakeups + 1;
		seen <= irq;
	end
	assign rises = wakeups;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the status interrupt block
// assumes the apb slave answers with no wait states
`timescale 1ns/1ps
`default_nettype none
module tb;
	import status_irq_pkg::*;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fifo = 0, ten = 0, warn = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq, fe, gclk, tick;
	logic [1:0] lock = 0, cen = 0, act = 0, rl, al, tt;
	logic [1:0][9:0] thr;
	logic [32:0] q[$]; // expected slave error and read data, oldest first
	int n_errors = 0, tests_run = 0, seed = 52, rises, n, k, h, dv[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
	status_interrupt_and_clock_out #(.DEBOUNCE_COUNT(4)) u_status_interrupt_and_clock_out (.clk(clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rateLock(lock),
		.controllerEnabled(cen), .activityRaw(act), .fifoMismatch(fifo), .thermalWarning(warn),
		.thermalShutdown(warn), .pinTenLevel(ten), .pinElevenLevel(ten), .irq(irq), .rateLockLevel(rl),
		.activityLevel(al), .fifoErrorLevel(fe), .activityThresholdType(tt),
		.activityThresholdTenthsDb(thr), .gpioClockOutput(gclk), .gpioClockTick(tick));
	irq_host_model u_irq_host_model (.clk(clk), .irq(irq), .rises(rises));
	initial forever #10 clk = ~clk;
	// ==========================================
	// compare, bus cycle and counting helpers
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one transfer; the wait is bounded so a dead slave ends the run
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			end_sim();
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		q.push_back({1'b0, e});
		apb(1'b0, a, 32'h0);
	endtask
	// counts ticks and high cycles of the divided clock over 48 cycles
	task automatic ticks(output int c, output int hi);
		c = 0;
		hi = 0;
		repeat (48) begin
			@(posedge clk);
			#1 c += tick;
			hi += gclk;
		end
	endtask
	// read data and error are judged at the edge that completes the access
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready && q.size() > 0) begin
			chk("prdata", q[0][31:0], prdata);
			chk("pslverr", q[0][32], pslverr);
			void'(q.pop_front());
		end
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(16'h1ce0, 32'h0600);
		rd(16'h1ce4, 32'h9b81);
		rd(16'h1100, 32'h0080);
		// unmapped word: reads zero with a slave error
		q.push_back({1'b1, 32'h0});
		apb(1'b0, 16'h0004, 32'h0);
		apb(1'b1, 16'h1ce4, 32'h8b81);
		@(posedge clk) fifo <= 1'b1;
		repeat (3) @(posedge clk);
		chk("irq", 1, irq);
		chk("fifoLevel", 1, fe);
		rd(16'h1cc8, 32'h1000);
		apb(1'b1, 16'h1d00, 32'h1);
		@(posedge clk) chk("irq", 0, irq);
		apb(1'b1, 16'h1d00, 32'h0);
		apb(1'b1, 16'h1cc4, 32'h0);
		@(posedge clk) chk("irq", 1, irq);
		apb(1'b1, 16'h1cc4, 32'h1000);
		@(posedge clk) chk("irq", 0, irq);
		fifo <= 1'b0;
		repeat (3) @(posedge clk);
		rd(16'h1cc4, 32'h0);
		repeat (4) begin
			ten <= ~ten;
			lock[0] <= ~lock[0];
			repeat (4) @(posedge clk);
			rd(16'h1cc0, 32'h0600);
			rd(16'h1cc4, 32'h0080);
			chk("irq", 0, irq);
			chk("lockLevel", lock[0], rl[0]);
			apb(1'b1, 16'h1cc0, 32'h0600);
			apb(1'b1, 16'h1cc4, 32'h0080);
		end
		// thermal inputs: a short pulse is filtered out, a steady level latches
		warn <= 1'b1;
		repeat (2) @(posedge clk);
		warn <= 1'b0;
		repeat (8) @(posedge clk);
		rd(16'h1cc4, 32'h0);
		warn <= 1'b1;
		repeat (8) @(posedge clk);
		rd(16'h1cc4, 32'h8001);
		apb(1'b1, 16'h1cc4, 32'h8001);
		for (n = 0; n < 32; n++) begin
			k = $random(seed);
			apb(1'b1, 16'h1100, {n[4:0], k[1:0], 9'h0c0});
			@(posedge clk) chk("levelThr", 300 + 15 * n, thr[0]);
			chk("thrType", 1, tt[0]);
			apb(1'b1, 16'h1100, {n[4:0], k[1:0], 9'h040});
			@(posedge clk) chk("crestThr", 120 + 60 * k[1:0], thr[0]);
			chk("thrType", 0, tt[0]);
		end
		act <= 2'b01;
		repeat (3) @(posedge clk);
		rd(16'h1cc4, 32'h0);
		chk("actLevel", 0, al[0]);
		act <= 2'b00;
		cen <= 2'b01;
		repeat (3) @(posedge clk);
		act <= 2'b01;
		repeat (3) @(posedge clk);
		rd(16'h1cc4, 32'h0200);
		chk("actLevel", 1, al[0]);
		apb(1'b1, 16'h1cc4, 32'h0200);
		act <= 2'b00;
		repeat (3) @(posedge clk);
		rd(16'h1cc4, 32'h0);
		// detect enable bit off: a rise is ignored even with the controller on
		apb(1'b1, 16'h1100, 32'h0080);
		act <= 2'b01;
		repeat (3) @(posedge clk);
		rd(16'h1cc4, 32'h0);
		for (n = 0; n < 8; n++) begin
			apb(1'b1, 16'h0824, n);
			apb(1'b1, 16'h0008, 32'h0800);
			repeat (16) @(posedge clk);
			ticks(k, h);
			chk("ticks", 48 / dv[n], k);
			chk("clkHigh", 48 / dv[n] * ((dv[n] + 1) / 2), h);
		end
		apb(1'b1, 16'h0008, 32'h0);
		ticks(k, h);
		chk("ticksOff", 0, k);
		chk("clkHighOff", 0, h);
		chk("rises", 2, rises);
		chk("pendingReads", 0, q.size());
		end_sim();
	end
endmodule
`default_nettype wire
